// *** hw/gpw_gpio_top.sv ***
`timescale 1ns/1ps
module gpw_gpio_top (
    input  wire logic                 sys_clk,
    input  wire logic                 sys_rst,
    input  wire gpw_pkg::gpw_wb_req_s wbReq,
    output logic                      wbAck,
    output logic [31:0]               wbDatOut,
    input  wire logic [35:0]          pinIn,
    output logic [35:0]               pinOut,
    output logic [35:0]               pinOe,
    output logic [35:0]               pinPull,
    output logic                      timerExtInput,
    output logic                      pwrDown
);
    gpw_pkg::gpw_top_s st;
    gpw_pkg::gpw_top_s next_st;

    logic        accPulse;
    logic        wrPulse;
    logic        rdPulse;
    logic        wrLane;
    logic        haltReq;
    logic [7:0]  wd;
    logic [3:0]  axisHit;
    logic [7:0]  statusSet;
    logic [7:0]  statusClr;
    logic [31:0] rdData;
    logic [39:0] pinPad;
    logic [39:0] readBack;
    logic [35:0] wakeMask;
    logic [35:0] pullMask;
    logic [4:0]  pullNext;

    // Bus slave: one-cycle registered acknowledge, any address answered.
    gpw_wb_slave u_slave (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .wbReq    (wbReq),
        .rdData   (rdData),
        .accPulse (accPulse),
        .wbAck    (wbAck),
        .wbDatOut (wbDatOut)
    );

    // Power-down and edge wake detection over the selected pins.
    gpw_wake u_wake (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .haltReq  (haltReq),
        .pinIn    (pinIn),
        .wakeMask (wakeMask),
        .pwrDown  (pwrDown),
        .axisHit  (axisHit)
    );

    // Access strobes; registers sit in byte lane 0.
    assign wrPulse = accPulse && wbReq.we;
    assign rdPulse = accPulse && !wbReq.we;
    assign wrLane  = wrPulse && wbReq.sel[0];
    assign wd      = wbReq.dat[7:0];
    assign haltReq = wrLane && (wbReq.adr == gpw_pkg::ADR_PWR) && wd[0];

    // Pull option as it stands after this edge, so pulls follow the write.
    assign pullNext = (wrLane && wbReq.adr == gpw_pkg::ADR_PULL)
                      ? wd[4:0] : st.pullSel;

    // Unused upper pins of port E pad the vector to five full bytes.
    assign pinPad = {4'h0, pinIn};

    // Inputs read the live pin, outputs read back their latch.
    assign readBack = ((st.dir & pinPad) | (~st.dir & st.latch))
                      & gpw_pkg::PIN_VALID;

    // Per-pin wake enable and pull-high option.
    generate
        for (genvar i = 0; i < gpw_pkg::NUM_PINS; i++)
        begin : g_pin
            if (i < gpw_pkg::PORT_BITS)
            begin : g_bit
                assign wakeMask[i] = st.wakeBitA[i];
            end
            else if (i >= gpw_pkg::AXIS_LSB && i < gpw_pkg::AXIS_LSB + 4)
            begin : g_axis
                assign wakeMask[i] = st.wakeNib[(i / 4) - 2]
                                     && st.axisEn[i - gpw_pkg::AXIS_LSB];
            end
            else
            begin : g_nib
                assign wakeMask[i] = st.wakeNib[(i / 4) - 2];
            end
            assign pullMask[i] = pullNext[i / gpw_pkg::PORT_BITS];
        end
    endgenerate

    // Axis wake flags land on their status bits.
    always_comb
    begin
        statusSet = '0;
        statusSet[gpw_pkg::STAT_V_FIRST]  = axisHit[0];
        statusSet[gpw_pkg::STAT_V_SECOND] = axisHit[1];
        statusSet[gpw_pkg::STAT_Z_FIRST]  = axisHit[2];
        statusSet[gpw_pkg::STAT_Z_SECOND] = axisHit[3];
        statusClr = '0;
        if (rdPulse && wbReq.adr == gpw_pkg::ADR_STATUS)
        begin
            statusClr = 8'hFF;
        end
    end

    // Read multiplexer.
    always_comb
    begin
        rdData = gpw_pkg::WORD_ZERO;
        if (wbReq.adr == gpw_pkg::ADR_DATA_A)
            rdData[7:0] = readBack[7:0];
        else if (wbReq.adr == gpw_pkg::ADR_DATA_B)
            rdData[7:0] = readBack[15:8];
        else if (wbReq.adr == gpw_pkg::ADR_DATA_C)
            rdData[7:0] = readBack[23:16];
        else if (wbReq.adr == gpw_pkg::ADR_DATA_D)
            rdData[7:0] = readBack[31:24];
        else if (wbReq.adr == gpw_pkg::ADR_DATA_E)
            rdData[3:0] = readBack[35:32];
        else if (wbReq.adr == gpw_pkg::ADR_DIR_A)
            rdData[7:0] = st.dir[7:0];
        else if (wbReq.adr == gpw_pkg::ADR_DIR_B)
            rdData[7:0] = st.dir[15:8];
        else if (wbReq.adr == gpw_pkg::ADR_DIR_C)
            rdData[7:0] = st.dir[23:16];
        else if (wbReq.adr == gpw_pkg::ADR_DIR_D)
            rdData[7:0] = st.dir[31:24];
        else if (wbReq.adr == gpw_pkg::ADR_DIR_E)
            rdData[3:0] = st.dir[35:32];
        else if (wbReq.adr == gpw_pkg::ADR_STATUS)
            rdData[7:0] = st.status;
        else if (wbReq.adr == gpw_pkg::ADR_WAKE_A)
            rdData[7:0] = st.wakeBitA;
        else if (wbReq.adr == gpw_pkg::ADR_WAKE_N)
            rdData[6:0] = st.wakeNib;
        else if (wbReq.adr == gpw_pkg::ADR_PULL)
            rdData[4:0] = st.pullSel;
        else if (wbReq.adr == gpw_pkg::ADR_AXIS)
            rdData[3:0] = st.axisEn;
        else if (wbReq.adr == gpw_pkg::ADR_PWR)
            rdData[0] = pwrDown;
    end

    // Register writes, status update and registered pin drive.
    always_comb
    begin
        next_st = st;
        if (wrLane)
        begin
            if (wbReq.adr == gpw_pkg::ADR_DATA_A)
                next_st.latch[7:0] = wd;
            else if (wbReq.adr == gpw_pkg::ADR_DATA_B)
                next_st.latch[15:8] = wd;
            else if (wbReq.adr == gpw_pkg::ADR_DATA_C)
                next_st.latch[23:16] = wd;
            else if (wbReq.adr == gpw_pkg::ADR_DATA_D)
                next_st.latch[31:24] = wd;
            else if (wbReq.adr == gpw_pkg::ADR_DATA_E)
                next_st.latch[35:32] = wd[3:0];
            else if (wbReq.adr == gpw_pkg::ADR_DIR_A)
                next_st.dir[7:0] = wd;
            else if (wbReq.adr == gpw_pkg::ADR_DIR_B)
                next_st.dir[15:8] = wd;
            else if (wbReq.adr == gpw_pkg::ADR_DIR_C)
                next_st.dir[23:16] = wd;
            else if (wbReq.adr == gpw_pkg::ADR_DIR_D)
                next_st.dir[31:24] = wd;
            else if (wbReq.adr == gpw_pkg::ADR_DIR_E)
                next_st.dir[35:32] = wd[3:0];
            else if (wbReq.adr == gpw_pkg::ADR_WAKE_A)
                next_st.wakeBitA = wd;
            else if (wbReq.adr == gpw_pkg::ADR_WAKE_N)
                next_st.wakeNib = wd[6:0];
            else if (wbReq.adr == gpw_pkg::ADR_PULL)
                next_st.pullSel = wd[4:0];
            else if (wbReq.adr == gpw_pkg::ADR_AXIS)
                next_st.axisEn = wd[3:0];
        end
        // A flag set in the cycle of its read survives the clear.
        next_st.status  = (st.status & ~statusClr) | statusSet;
        next_st.pinOut  = next_st.latch[35:0];
        next_st.pinOe   = ~next_st.dir[35:0];
        next_st.pinPull = next_st.dir[35:0] & pullMask;
        next_st.timerIn = pinIn[gpw_pkg::TIMER_PIN];
    end

    // State register; reset leaves every pin an input with latch high.
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            st          <= '0;
            st.latch    <= gpw_pkg::LATCH_RST;
            st.dir      <= gpw_pkg::DIR_RST;
            st.wakeBitA <= gpw_pkg::BYTE_RST;
            st.pinOut   <= gpw_pkg::LATCH_RST[35:0];
        end
        else
        begin
            st <= next_st;
        end
    end

    assign pinOut        = st.pinOut;
    assign pinOe         = st.pinOe;
    assign pinPull       = st.pinPull;
    assign timerExtInput = st.timerIn;

    // Checks on the port, status and bus behaviour.
    sequence s_status_read;
        rdPulse && wbReq.adr == gpw_pkg::ADR_STATUS;
    endsequence

    sequence s_port_a_read;
        rdPulse && wbReq.adr == gpw_pkg::ADR_DATA_A;
    endsequence

    a_reset_all_high: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $past(sys_rst) |-> pinOe == 36'h0 && pinOut == 36'hF_FFFF_FFFF)
        else $error("Pins not inputs with high latch after reset.");

    a_pull_input_only: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (pinOe & pinPull) == 36'h0
            && (st.pullSel[0] || pinPull[7:0] == 8'h00))
        else $error("Pull-high enabled on a driving pin.");

    a_latch_holds: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !wrLane ##1 1'b1 |-> pinOut == $past(pinOut))
        else $error("Output latch changed without a write.");

    a_port_a_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
        s_port_a_read |=> wbAck
            && wbDatOut[7:0] == $past((st.dir[7:0] & pinIn[7:0])
                                      | (~st.dir[7:0] & st.latch[7:0])))
        else $error("Port A read did not mix pin and latch by direction.");

    a_status_clear: assert property (@(posedge sys_clk) disable iff (sys_rst)
        s_status_read and (axisHit == 4'h0) |=> st.status == 8'h00)
        else $error("Status flags survived a read.");

    a_axis_flags_set: assert property (@(posedge sys_clk) disable iff (sys_rst)
        axisHit[1] && axisHit[3] |=> st.status[4] && st.status[7])
        else $error("Axis wake did not set its status flags.");

    a_other_flags_keep: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !rdPulse && axisHit == 4'h1 |=> st.status[7:4] == $past(st.status[7:4]))
        else $error("Uninvolved wake flag changed.");

    a_halt_enters: assert property (@(posedge sys_clk) disable iff (sys_rst)
        haltReq && !pwrDown |=> pwrDown)
        else $error("Halt write did not enter power-down.");
endmodule : gpw_gpio_top

// *** hw/gpw_pkg.sv ***
package gpw_pkg;
    // Behaviour
    // - Thirty-six two-way lines in five ports, each usable as input or output.
    // - Input reads are not latched; the pin level is taken at the read.
    // - Written output data stays in its latch until rewritten.
    // - Weak pull-high only on input pins whose pull-high option is selected.
    // - Halt stops the clock until a selected wake pin changes either way.
    // - Wake enable per bit on port A, per nibble on ports B to E.
    // - Direction bit 1 makes an input; a read returns the pin level.
    // - Direction bit 0 makes a CMOS output driving the output latch.
    // - Reading an output bit returns the latch, not the pin level.
    // - Axis pins on D bits 0 to 3 wake only when their option is on.
    // - Wake by D bit 0 sets status bit 3, D bit 1 sets bit 4.
    // - Wake by D bit 2 sets status bit 6, D bit 3 sets bit 7.
    // - Each wake status flag clears when software reads it.
    // - Reset sets every data latch and direction bit high.
    // - Bit set and clear read the whole port, modify, write back.

    localparam int NUM_PINS  = 36;
    localparam int PAD_PINS  = 40;
    localparam int PORT_BITS = 8;
    localparam int NIB_BITS  = 4;
    localparam int NUM_NIBS  = 7;
    localparam int NUM_PORTS = 5;
    localparam int AXIS_LSB  = 24;
    localparam int TIMER_PIN = 2;

    // Register byte addresses on the bus.
    localparam logic [7:0] ADR_DATA_A = 8'h00;
    localparam logic [7:0] ADR_DATA_B = 8'h04;
    localparam logic [7:0] ADR_DATA_C = 8'h08;
    localparam logic [7:0] ADR_DATA_D = 8'h0C;
    localparam logic [7:0] ADR_DATA_E = 8'h10;
    localparam logic [7:0] ADR_DIR_A  = 8'h14;
    localparam logic [7:0] ADR_DIR_B  = 8'h18;
    localparam logic [7:0] ADR_DIR_C  = 8'h1C;
    localparam logic [7:0] ADR_DIR_D  = 8'h20;
    localparam logic [7:0] ADR_DIR_E  = 8'h24;
    localparam logic [7:0] ADR_STATUS = 8'h28;
    localparam logic [7:0] ADR_WAKE_A = 8'h2C;
    localparam logic [7:0] ADR_WAKE_N = 8'h30;
    localparam logic [7:0] ADR_PULL   = 8'h34;
    localparam logic [7:0] ADR_AXIS   = 8'h38;
    localparam logic [7:0] ADR_PWR    = 8'h3C;

    // Status bit positions of the four axis wake flags.
    localparam int STAT_V_FIRST  = 3;
    localparam int STAT_V_SECOND = 4;
    localparam int STAT_Z_FIRST  = 6;
    localparam int STAT_Z_SECOND = 7;

    // Reset values.
    localparam logic [39:0] LATCH_RST = 40'hFF_FFFF_FFFF;
    localparam logic [39:0] DIR_RST   = 40'hFF_FFFF_FFFF;
    localparam logic [39:0] PIN_VALID = 40'h0F_FFFF_FFFF;
    localparam logic [7:0]  BYTE_RST  = 8'h00;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    typedef enum logic [1:0] {
        PWR_RUN  = 2'b01,
        PWR_DOWN = 2'b10
    } gpw_pwr_e;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } gpw_wb_req_s;

    typedef struct packed {
        logic [39:0] latch;
        logic [39:0] dir;
        logic [7:0]  wakeBitA;
        logic [6:0]  wakeNib;
        logic [4:0]  pullSel;
        logic [3:0]  axisEn;
        logic [7:0]  status;
        logic [35:0] pinOut;
        logic [35:0] pinOe;
        logic [35:0] pinPull;
        logic        timerIn;
    } gpw_top_s;
endpackage : gpw_pkg

// *** hw/gpw_wb_slave.sv ***
`timescale 1ns/1ps
module gpw_wb_slave (
    input  wire logic                 sys_clk,
    input  wire logic                 sys_rst,
    input  wire gpw_pkg::gpw_wb_req_s wbReq,
    input  wire logic [31:0]          rdData,
    output logic                      accPulse,
    output logic                      wbAck,
    output logic [31:0]               wbDatOut
);
    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } gpw_slv_s;

    gpw_slv_s st;
    gpw_slv_s next_st;

    // An access is taken once, in the cycle before its acknowledge.
    assign accPulse = wbReq.cyc && wbReq.stb && !st.ack;

    // Acknowledge one cycle after the request; read data rides with it.
    always_comb
    begin
        next_st     = st;
        next_st.ack = accPulse;
        next_st.dat = accPulse ? rdData : gpw_pkg::WORD_ZERO;
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign wbAck    = st.ack;
    assign wbDatOut = st.dat;

    a_ack_single_pulse: assert property (@(posedge sys_clk) disable iff (sys_rst)
        wbAck |=> !wbAck)
        else $error("Acknowledge lasted more than one cycle.");
endmodule : gpw_wb_slave

// *** hw/gpw_wake.sv ***
`timescale 1ns/1ps
module gpw_wake (
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic        haltReq,
    input  wire logic [35:0] pinIn,
    input  wire logic [35:0] wakeMask,
    output logic             pwrDown,
    output logic [3:0]       axisHit
);
    typedef struct packed {
        gpw_pkg::gpw_pwr_e mode;
        logic [35:0]       refLevel;
        logic [3:0]        hit;
    } gpw_wake_s;

    gpw_wake_s   st;
    gpw_wake_s   next_st;
    logic [35:0] change;

    // Any selected pin that differs from its level at halt time.
    assign change = (pinIn ^ st.refLevel) & wakeMask;

    // Halt captures the pin levels; a change in either direction wakes.
    always_comb
    begin
        next_st     = st;
        next_st.hit = '0;
        case (st.mode)
            gpw_pkg::PWR_RUN:
            begin
                if (haltReq)
                begin
                    next_st.mode     = gpw_pkg::PWR_DOWN;
                    next_st.refLevel = pinIn;
                end
            end
            gpw_pkg::PWR_DOWN:
            begin
                if (|change)
                begin
                    next_st.mode = gpw_pkg::PWR_RUN;
                    next_st.hit  = change[gpw_pkg::AXIS_LSB +: 4];
                end
            end
            default:
            begin
                next_st.mode = gpw_pkg::PWR_RUN;
            end
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            st <= '{mode: gpw_pkg::PWR_RUN, refLevel: '0, hit: '0};
        end
        else
        begin
            st <= next_st;
        end
    end

    // The one-hot down bit is the flag itself, straight from its flip-flop.
    assign pwrDown = st.mode[1];
    assign axisHit = st.hit;

    a_wake_on_change: assert property (@(posedge sys_clk) disable iff (sys_rst)
        pwrDown && (|change) |=> !pwrDown)
        else $error("Selected pin changed but the device stayed down.");

    a_stay_down: assert property (@(posedge sys_clk) disable iff (sys_rst)
        pwrDown && !(|change) |=> pwrDown && axisHit == 4'h0)
        else $error("Device left power-down without a wake change.");
endmodule : gpw_wake

// *** bench/gpw_pin_model.sv ***
`timescale 1ns/1ps
module gpw_pin_model (
    input  wire logic        sys_clk,
    input  wire logic [35:0] swLevel,
    input  wire logic [35:0] swDrive,
    input  wire logic [35:0] pinOut,
    input  wire logic [35:0] pinOe,
    input  wire logic [35:0] pinPull,
    output logic      [35:0] pinIn
);
    logic [35:0] floatLevel;

    // A line nobody drives or pulls wanders every cycle, so no stale level.
    initial floatLevel = 36'h5_5555_5555;
    always @(posedge sys_clk)
        floatLevel <= ~floatLevel;

    // The wire takes the device driver first, then a switch, then the pull.
    always_comb
        pinIn = (pinOe & pinOut)
              | (~pinOe & swDrive & swLevel)
              | (~pinOe & ~swDrive & pinPull)
              | (~pinOe & ~swDrive & ~pinPull & floatLevel);
endmodule : gpw_pin_model

// *** bench/tb_gpw_gpio_top.sv ***
`timescale 1ns/1ps
module tb_gpw_gpio_top;
    localparam logic [39:0] PAT = 40'h0A_9C5A_33C5;
    logic                 sys_clk;
    logic                 sys_rst;
    gpw_pkg::gpw_wb_req_s wbReq;
    logic                 wbAck;
    logic [31:0]          wbDatOut;
    logic [35:0]          pinIn;
    logic [35:0]          pinOut;
    logic [35:0]          pinOe;
    logic [35:0]          pinPull;
    logic                 timerExtInput;
    logic                 pwrDown;
    logic [35:0]          swLevel;
    logic [35:0]          swDrive;
    logic [7:0]           rd;
    int                   n_errors;
    int                   n_compared;

    // The block and the switches on its pins.
    gpw_gpio_top u_dut (
        .sys_clk       (sys_clk),
        .sys_rst       (sys_rst),
        .wbReq         (wbReq),
        .wbAck         (wbAck),
        .wbDatOut      (wbDatOut),
        .pinIn         (pinIn),
        .pinOut        (pinOut),
        .pinOe         (pinOe),
        .pinPull       (pinPull),
        .timerExtInput (timerExtInput),
        .pwrDown       (pwrDown)
    );
    gpw_pin_model u_pins (
        .sys_clk (sys_clk),
        .swLevel (swLevel),
        .swDrive (swDrive),
        .pinOut  (pinOut),
        .pinOe   (pinOe),
        .pinPull (pinPull),
        .pinIn   (pinIn)
    );

    // The clock runs at 20 MHz.
    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // Prints the verdict and ends the run.
    task automatic final_report;
        if (n_errors == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : final_report

    // Compares one value and reports a difference.
    task automatic check(input logic [35:0] got, input logic [35:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask : check

    // One classic bus cycle; the request holds until ack is sampled.
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [7:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        wbReq <= '{1'b1, 1'b1, w, a, 4'h1, {24'h0, d}};
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (wbAck !== 1'b1 && n < 20);
        rd = wbDatOut[7:0];
        wbReq <= '0;
        if (wbAck !== 1'b1)
        begin
            n_errors++;
            final_report();
        end
    endtask : wb

    // Reads a register and compares its byte.
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        wb(1'b0, a, 8'h00);
        check({28'h0, rd}, {28'h0, e});
    endtask : rchk

    // Waits a bounded time for the power-down flag to reach a level.
    task automatic wait_pd(input logic v);
        int n;
        for (n = 0; n < 10 && pwrDown !== v; n++)
            @(posedge sys_clk);
        check({35'h0, pwrDown}, {35'h0, v});
        if (pwrDown !== v)
            final_report();
    endtask : wait_pd

    // Halts, moves a pin that must not wake, then one that must.
    task automatic wake(input logic [7:0] ax, input logic [35:0] dud,
                        input logic [35:0] flip, input logic [7:0] st);
        wb(1'b1, gpw_pkg::ADR_AXIS, ax);
        rchk(gpw_pkg::ADR_AXIS, ax);
        wb(1'b1, gpw_pkg::ADR_PWR, 8'h01);
        wait_pd(1'b1);
        swLevel <= swLevel ^ dud;
        repeat (5) @(posedge sys_clk);
        check({35'h0, pwrDown}, 36'h1);
        swLevel <= swLevel ^ flip;
        wait_pd(1'b0);
        rchk(gpw_pkg::ADR_STATUS, st);
        rchk(gpw_pkg::ADR_STATUS, 8'h00);
        rchk(gpw_pkg::ADR_PWR, 8'h00);
    endtask : wake

    // Main sequence.
    initial
    begin
        sys_rst = 1'b1;
        wbReq = '0;
        swLevel = PAT[35:0];
        swDrive = '1;
        n_errors = 0;
        n_compared = 0;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        check(pinOe, 36'h0);
        check(pinOut, {36{1'b1}});
        check(pinPull, 36'h0);
        for (int p = 0; p < 5; p++)
        begin
            rchk(gpw_pkg::ADR_DIR_A + 8'(4 * p),
                 gpw_pkg::DIR_RST[8*p +: 8] &
                 gpw_pkg::PIN_VALID[8*p +: 8]);
            rchk(gpw_pkg::ADR_DATA_A + 8'(4 * p), PAT[8*p +: 8]);
        end
        check({35'h0, timerExtInput}, {35'h0, PAT[2]});
        wb(1'b1, 8'h40, 8'hFF);
        rchk(8'h40, 8'h00);
        rchk(gpw_pkg::ADR_STATUS, 8'h00);
        // Low nibble of port A becomes output, then the pins move.
        wb(1'b1, gpw_pkg::ADR_DATA_A, 8'h5A);
        check(pinOe, 36'h0);
        wb(1'b1, gpw_pkg::ADR_DIR_A, 8'hF0);
        check(pinOe, 36'h0_0000_000F);
        check(pinOut, {28'hFFF_FFFF, 8'h5A});
        swLevel <= ~PAT[35:0];
        rchk(gpw_pkg::ADR_DATA_A, {~PAT[7:4], 4'hA});
        check(pinOut, {28'hFFF_FFFF, 8'h5A});
        // A bit set by reading the whole port and writing it back.
        wb(1'b0, gpw_pkg::ADR_DATA_A, 8'h00);
        wb(1'b1, gpw_pkg::ADR_DATA_A, rd | 8'h01);
        check(pinOut, {28'hFFF_FFFF, ~PAT[7:4], 4'hB});
        check({35'h0, timerExtInput}, 36'h0);
        // Pull-high only on inputs of ports whose option is on.
        wb(1'b1, gpw_pkg::ADR_PULL, 8'h1F);
        check(pinPull, 36'hF_FFFF_FFF0);
        rchk(gpw_pkg::ADR_PULL, 8'h1F);
        swDrive <= 36'h0_FFFF_FFFF;
        rchk(gpw_pkg::ADR_DATA_E, 8'h0F);
        wb(1'b1, gpw_pkg::ADR_PULL, 8'h0F);
        check(pinPull, 36'h0_FFFF_FFF0);
        swDrive <= '1;
        // Wake from power-down through axis, per-bit and nibble enables.
        wb(1'b1, gpw_pkg::ADR_WAKE_N, 8'h10);
        rchk(gpw_pkg::ADR_WAKE_N, 8'h10);
        wake(8'h0A, 36'h0_0500_0000, 36'h0_0A00_0000, 8'h90);
        wake(8'h0F, 36'h0_0000_0010, 36'h0_0500_0000, 8'h48);
        wb(1'b1, gpw_pkg::ADR_WAKE_A, 8'h20);
        rchk(gpw_pkg::ADR_WAKE_A, 8'h20);
        wake(8'h00, 36'h0_0000_0010, 36'h0_0000_0020, 8'h00);
        wake(8'h01, 36'h0_0000_0100, 36'h0_0100_0000, 8'h08);
        final_report();
    end
endmodule : tb_gpw_gpio_top
